// ---- src/uar_map.svh ----
/*
 * Constants of the serial address recognition block: reset values,
 * timer limits and divider tops.
 * Assumes inclusion by bare name from the block's source files.
 */
`ifndef UAR_MAP_SVH
`define UAR_MAP_SVH

// Reset value of both address registers
`define UAR_ADDR_RST 8'h00
// Reset value of the timer reload and counter
`define UAR_T1_RST 8'h00
// Counter value at which the eight-bit timer overflows
`define UAR_T1_TOP 8'hFF
// Peripheral clocks per timer increment
`define UAR_T1_PRESCALE 6
// Prescaler reset value, loaded again after its terminal count
`define UAR_PRE_RST 8'h00
// Sample ticks per serial bit, minus one
`define UAR_SAMPLE_TOP 4'hF
`define UAR_SAMPLE_RST 4'h0

`endif

// ---- src/uar_pkg.sv ----
/*
 * Types of the serial address recognition block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package uar_pkg;

  // Which of the two addresses picked the current data stream
  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_GIVEN,
    SEL_BCAST
  } uar_sel_t;

  typedef struct packed {
    logic [7:0] prescale;
    logic [7:0] count;
    logic [7:0] reload;
    logic half;
    logic [3:0] samples;
    logic overflow;
    logic sample_tick;
    logic bit_tick;
  } uar_t1_state_t;

  typedef struct packed {
    logic [7:0] slave_address_reg;
    logic [7:0] mask;
    logic [7:0] bcast;
    uar_sel_t sel;
    logic given_hit;
    logic bcast_hit;
    logic addr_event;
    logic accept;
    logic [7:0] accept_data;
    logic selected;
  } uar_ar_state_t;

endpackage

`default_nettype wire

// ---- src/uar_t1_baud.sv ----
/*
 * Timer 1 in eight-bit auto-reload mode used as a baud source.
 * Assumes control ports come from logic on mclk_i.
 */
`default_nettype none
`include "uar_map.svh"

module uar_t1_baud #(
  parameter int PRESCALE = `UAR_T1_PRESCALE
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic run_i,
  input wire logic src_sel_i,
  input wire logic double_i,
  input wire logic reload_wr_i,
  input wire logic [7:0] reload_wdata_i,
  output logic [7:0] reload_o,
  output logic [7:0] count_o,
  output logic overflow_o,
  output logic sample_tick_o,
  output logic bit_tick_o
);

  uar_pkg::uar_t1_state_t s_q;
  uar_pkg::uar_t1_state_t s_d;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic inc;
    logic ovf;
    logic samp;
    s_d = s_q;
    inc = 1'b0;
    ovf = 1'b0;
    samp = 1'b0;
    s_d.overflow = 1'b0;
    s_d.sample_tick = 1'b0;
    s_d.bit_tick = 1'b0;
    if (reload_wr_i) begin
      s_d.reload = reload_wdata_i;
    end
    if (run_i) begin
      if (s_q.prescale == 8'(PRESCALE - 1)) begin
        s_d.prescale = `UAR_PRE_RST;
        inc = 1'b1;
      end else begin
        s_d.prescale = s_q.prescale + 8'h01;
      end
    end
    if (inc) begin
      if (s_q.count == `UAR_T1_TOP) begin
        s_d.count = s_q.reload;
        ovf = 1'b1;
      end else begin
        s_d.count = s_q.count + 8'h01;
      end
    end
    s_d.overflow = ovf;
    if (!src_sel_i) begin
      // Dividers held so the first bit after selection is full length
      s_d.half = 1'b0;
      s_d.samples = `UAR_SAMPLE_RST;
    end else if (ovf) begin
      // Without doubling two overflows make one sample tick
      if (double_i) begin
        samp = 1'b1;
      end else begin
        s_d.half = ~s_q.half;
        samp = s_q.half;
      end
      s_d.sample_tick = samp;
      if (samp) begin
        s_d.samples = s_q.samples + 4'h1;
        s_d.bit_tick = (s_q.samples == `UAR_SAMPLE_TOP);
      end
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_q <= '{prescale: `UAR_PRE_RST, count: `UAR_T1_RST, reload: `UAR_T1_RST, half: 1'b0,
               samples: `UAR_SAMPLE_RST, overflow: 1'b0, sample_tick: 1'b0, bit_tick: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign reload_o = s_q.reload;
  assign count_o = s_q.count;
  assign overflow_o = s_q.overflow;
  assign sample_tick_o = s_q.sample_tick;
  assign bit_tick_o = s_q.bit_tick;

endmodule // uar_t1_baud

`default_nettype wire

// ---- src/uar_addr_recog.sv ----
/*
 * Automatic address recognition for a multiprocessor serial port,
 * with Timer 1 as an auto-reload baud source.
 * Assumes the receiver and the CPU side run on mclk_i and present
 * each received byte as a one-cycle strobe.
 */
// Contract
// - Broadcast address is slave address OR mask
// - Reset clears slave address and mask registers
// - Timer 1 overflows give serial bit timing
// - Timer 1 eight-bit, reloads from high byte
// - Baud doubling bit makes each Timer 1 overflow a sample tick; Timer 1 rate is unchanged
`default_nettype none
`include "uar_map.svh"

module uar_addr_recog #(
  parameter int T1_PRESCALE = `UAR_T1_PRESCALE
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic slave_address_reg_wr_i,
  input wire logic [7:0] slave_address_reg_wdata_i,
  input wire logic mask_wr_i,
  input wire logic [7:0] mask_wdata_i,
  input wire logic multiproc_en_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_bit9_i,
  input wire logic t1_run_i,
  input wire logic t1_baud_sel_i,
  input wire logic baud_double_bit_i,
  input wire logic t1_reload_wr_i,
  input wire logic [7:0] t1_reload_wdata_i,
  output logic [7:0] slave_address_reg_o,
  output logic [7:0] slave_address_mask_reg_o,
  output logic [7:0] broadcast_addr_o,
  output logic addr_event_o,
  output logic given_hit_o,
  output logic broadcast_hit_o,
  output logic selected_o,
  output logic rx_accept_o,
  output logic [7:0] rx_accept_data_o,
  output logic [7:0] t1_reload_o,
  output logic [7:0] t1_count_o,
  output logic t1_overflow_o,
  output logic baud_sample_tick_o,
  output logic baud_bit_tick_o
);

  uar_pkg::uar_ar_state_t s_q;
  uar_pkg::uar_ar_state_t s_d;

  // ****************************************
  // Address matching
  // ****************************************
  logic given_hit;
  logic bcast_hit;

  // Mask-zero bits are don't care; all-zero mask matches anything
  assign given_hit = ((rx_data_i ^ s_q.slave_address_reg) & s_q.mask) == `UAR_ADDR_RST;
  // Zero bits of the broadcast address are don't care, so the byte only
  // needs ones where the broadcast address has ones
  assign bcast_hit = (rx_data_i & s_q.bcast) == s_q.bcast;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.addr_event = 1'b0;
    s_d.accept = 1'b0;
    if (slave_address_reg_wr_i) begin
      s_d.slave_address_reg = slave_address_reg_wdata_i;
    end
    if (mask_wr_i) begin
      s_d.mask = mask_wdata_i;
    end
    // Kept registered so the compare path is one gate level shorter
    s_d.bcast = s_d.slave_address_reg | s_d.mask;
    if (rx_valid_i) begin
      if (!multiproc_en_i) begin
        // Filter off: every byte goes through, selection is dropped
        s_d.accept = 1'b1;
        s_d.accept_data = rx_data_i;
        s_d.sel = uar_pkg::SEL_NONE;
      end else if (rx_bit9_i) begin
        s_d.addr_event = 1'b1;
        s_d.given_hit = given_hit;
        s_d.bcast_hit = bcast_hit;
        case ({given_hit, bcast_hit})
          2'b10,
          2'b11: begin
            s_d.sel = uar_pkg::SEL_GIVEN;
            s_d.accept = 1'b1;
            s_d.accept_data = rx_data_i;
          end
          2'b01: begin
            // An all-ones address from the master lands here when it misses the given address
            s_d.sel = uar_pkg::SEL_BCAST;
            s_d.accept = 1'b1;
            s_d.accept_data = rx_data_i;
          end
          default: begin
            s_d.sel = uar_pkg::SEL_NONE;
          end
        endcase
      end else begin
        // Data bytes pass only after a matching address
        case (s_q.sel)
          uar_pkg::SEL_GIVEN,
          uar_pkg::SEL_BCAST: begin
            s_d.accept = 1'b1;
            s_d.accept_data = rx_data_i;
          end
          default: begin
            s_d.accept = 1'b0;
          end
        endcase
      end
    end
    // Registered so the output comes straight from a flip-flop
    s_d.selected = (s_d.sel != uar_pkg::SEL_NONE);
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_q <= '{slave_address_reg: `UAR_ADDR_RST, mask: `UAR_ADDR_RST, bcast: `UAR_ADDR_RST,
               sel: uar_pkg::SEL_NONE, given_hit: 1'b0, bcast_hit: 1'b0,
               addr_event: 1'b0, accept: 1'b0, accept_data: `UAR_ADDR_RST, selected: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign slave_address_reg_o = s_q.slave_address_reg;
  assign slave_address_mask_reg_o = s_q.mask;
  assign broadcast_addr_o = s_q.bcast;
  assign addr_event_o = s_q.addr_event;
  assign given_hit_o = s_q.given_hit;
  assign broadcast_hit_o = s_q.bcast_hit;
  assign selected_o = s_q.selected;
  assign rx_accept_o = s_q.accept;
  assign rx_accept_data_o = s_q.accept_data;

  // ****************************************
  // Timer 1 baud source
  // ****************************************
  uar_t1_baud #(
    .PRESCALE(T1_PRESCALE)
  ) u_t1 (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .run_i(t1_run_i),
    .src_sel_i(t1_baud_sel_i),
    .double_i(baud_double_bit_i),
    .reload_wr_i(t1_reload_wr_i),
    .reload_wdata_i(t1_reload_wdata_i),
    .reload_o(t1_reload_o),
    .count_o(t1_count_o),
    .overflow_o(t1_overflow_o),
    .sample_tick_o(baud_sample_tick_o),
    .bit_tick_o(baud_bit_tick_o)
  );

endmodule // uar_addr_recog

`default_nettype wire

// ---- verif/uar_master_model.sv ----
/* Master node model: sends bytes to the slave as receive strobes.
   Assumes calls start after reset. */
`default_nettype none
module uar_master_model (
  input wire logic mclk_i,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic rx_bit9_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // Byte sender
  // ********
  initial {rx_valid_o, rx_data_o, rx_bit9_o} = 10'h0AA;
  task automatic send(input logic [7:0] b, input logic adr);
    @(posedge mclk_i) #1;
    {rx_valid_o, rx_data_o, rx_bit9_o} = {1'b1, b, adr};
    @(posedge mclk_i) #1;
    // Released lines show inverted data, so a stale byte never looks fresh
    {rx_valid_o, rx_data_o, rx_bit9_o} = {1'b0, ~b, ~adr};
  endtask
endmodule // uar_master_model
`default_nettype wire

// ---- verif/uar_addr_recog_properties.sv ----
/* Port checker of the address recognition block.
   Assumes one clock and the filter held on by the bench. */
`default_nettype none
module uar_addr_recog_properties (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_bit9_i,
  input wire logic [7:0] slave_address_reg_o,
  input wire logic [7:0] slave_address_mask_reg_o,
  input wire logic [7:0] broadcast_addr_o,
  input wire logic addr_event_o,
  input wire logic given_hit_o,
  input wire logic broadcast_hit_o,
  input wire logic [7:0] t1_reload_o,
  input wire logic [7:0] t1_count_o,
  input wire logic t1_overflow_o,
  input wire logic baud_sample_tick_o,
  input wire logic baud_bit_tick_o
);
  // ********
  // Properties
  // ********
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);
  wire logic adr = rx_valid_i && rx_bit9_i;
  property p_bc; broadcast_addr_o == (slave_address_reg_o | slave_address_mask_reg_o); endproperty
  a_bc: assert property (p_bc) else $error("bad broadcast");
  property p_rst; $rose(resetn_i) |-> {slave_address_reg_o, slave_address_mask_reg_o} == 16'h0000; endproperty
  a_rst: assert property (p_rst) else $error("bad reset");
  property p_gh; adr |=> addr_event_o && given_hit_o == ((($past(rx_data_i) ^ $past(slave_address_reg_o))
    & $past(slave_address_mask_reg_o)) == 8'h00); endproperty
  a_gh: assert property (p_gh) else $error("bad given");
  property p_bh; adr |=> broadcast_hit_o == (($past(rx_data_i) & $past(broadcast_addr_o)) == $past(broadcast_addr_o));
  endproperty
  a_bh: assert property (p_bh) else $error("bad bcast hit");
  property p_any; adr && slave_address_mask_reg_o == 8'h00 |=> given_hit_o; endproperty
  a_any: assert property (p_any) else $error("open miss");
  property p_rl; t1_overflow_o |-> t1_count_o == $past(t1_reload_o); endproperty
  a_rl: assert property (p_rl) else $error("bad reload");
  property p_ff; t1_overflow_o |-> $past(t1_count_o) == 8'hFF; endproperty
  a_ff: assert property (p_ff) else $error("bad wrap");
  property p_bt; baud_bit_tick_o |-> baud_sample_tick_o ##1 !baud_bit_tick_o; endproperty
  a_bt: assert property (p_bt) else $error("bad bit tick");
  c_g: cover property (adr ##1 given_hit_o);
  c_b: cover property (adr ##1 broadcast_hit_o && !given_hit_o);
  c_t: cover property (baud_bit_tick_o);
endmodule // uar_addr_recog_properties
bind uar_addr_recog uar_addr_recog_properties u_props (.*);
`default_nettype wire

// ---- verif/uar_addr_recog_tb_top.sv ----
/* Bench top: queues expected address results, a monitor checks them.
   Assumes the master model and the bound checker. */
`default_nettype none
module uar_addr_recog_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i, resetn_i, slave_address_reg_wr_i, mask_wr_i, multiproc_en_i, rx_valid_i, rx_bit9_i, t1_run_i;
  logic t1_baud_sel_i, baud_double_bit_i, t1_reload_wr_i, addr_event_o, given_hit_o, broadcast_hit_o;
  logic selected_o, rx_accept_o, t1_overflow_o, baud_sample_tick_o, baud_bit_tick_o;
  logic [7:0] slave_address_reg_wdata_i, mask_wdata_i, rx_data_i, t1_reload_wdata_i, slave_address_reg_o, cs, cm;
  logic [7:0] slave_address_mask_reg_o, broadcast_addr_o, rx_accept_data_o, t1_reload_o, t1_count_o;
  logic [11:0] exp_q[$];
  logic [47:0] slv = 48'hF1FA_F3F9_F2FD;
  logic [39:0] ads = 40'hF0_F3F1_FBFF;
  integer seed = 32'h06bc_f1a0;
  int num_errors = 0;
  int check_count = 0;
  uar_addr_recog #(.T1_PRESCALE(1)) dut (.*);
  uar_master_model u_master (.mclk_i, .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i), .rx_bit9_o(rx_bit9_i));
  // ********
  // Tasks and monitor
  // ********
  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end
  task automatic chk(input logic bad);
    check_count++;
    if (bad !== 1'b0) begin
      num_errors++;
      $display("Error at %0t: mismatch", $time);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic set_addr(input logic [7:0] s, input logic [7:0] m);
    @(posedge mclk_i) #1;
    {slave_address_reg_wr_i, slave_address_reg_wdata_i, mask_wr_i, mask_wdata_i, cs, cm} = {1'b1, s, 1'b1, m, s, m};
    @(posedge mclk_i) #1;
    {slave_address_reg_wr_i, mask_wr_i} = 2'b00;
    chk({slave_address_reg_o, broadcast_addr_o} !== {s, s | m});
  endtask
  task automatic addr(input logic [7:0] a);
    logic g;
    logic b;
    g = ((a ^ cs) & cm) == 8'h00;
    b = (a & (cs | cm)) == (cs | cm);
    exp_q.push_back({g, b, g | b, g | b, a});
    u_master.send(a, 1'b1);
  endtask
  // Counts overflows in one bit period, from one bit tick to the next
  task automatic tmr(input logic d, input int want);
    int n;
    int k;
    @(posedge mclk_i) #1;
    baud_double_bit_i = d;
    k = -1;
    for (n = 0; n < 4000; n++) begin
      @(posedge mclk_i) #2;
      if (k >= 0 && t1_overflow_o === 1'b1) k++;
      if (baud_bit_tick_o === 1'b1 && k >= 0) break;
      if (baud_bit_tick_o === 1'b1) k = 0;
    end
    if (n == 4000) begin
      chk(1'b1);
      give_verdict();
    end else begin
      chk(k != want);
    end
  endtask
  // Looks mid-cycle so the one-cycle result pulse is settled
  always @(negedge mclk_i) begin : mon
    logic [11:0] e;
    if (addr_event_o === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk(1'b1);
      end else begin
        e = exp_q.pop_front();
        chk({given_hit_o, broadcast_hit_o, rx_accept_o, selected_o} !== e[11:8]);
        if (e[8]) chk(rx_accept_data_o !== e[7:0]);
      end
    end
  end
  initial begin
    {slave_address_reg_wr_i, mask_wr_i, t1_run_i, t1_baud_sel_i, baud_double_bit_i, t1_reload_wr_i, resetn_i} = '0;
    {slave_address_reg_wdata_i, mask_wdata_i, t1_reload_wdata_i, cs, cm} = '0;
    multiproc_en_i = 1'b1;
    repeat (12) @(posedge mclk_i);
    #1 resetn_i = 1'b1;
    chk({slave_address_reg_o, slave_address_mask_reg_o} !== 16'h0000);
    addr(8'($random(seed)));
    for (int i = 0; i < 3; i++) begin
      set_addr(slv[47 - 16 * i -: 8], slv[39 - 16 * i -: 8]);
      for (int j = 0; j < 5; j++) addr(ads[8 * j +: 8]);
    end
    repeat (12) begin
      set_addr(8'($random(seed)), 8'($random(seed)));
      addr(cs);
      addr(8'($random(seed)) | cs | cm);
    end
    @(posedge mclk_i) #1;
    {t1_reload_wr_i, t1_reload_wdata_i} = {1'b1, 4'hF, 4'($random(seed))};
    @(posedge mclk_i) #1;
    {t1_reload_wr_i, t1_run_i, t1_baud_sel_i} = 3'b011;
    tmr(1'b1, 16);
    tmr(1'b0, 32);
    chk(exp_q.size() != 0);
    give_verdict();
  end
endmodule // uar_addr_recog_tb_top
`default_nettype wire
